// ### verilog/avc_top.sv
// Stereo ADC digital volume, mute and power control with a sample FIFO.
// Assumes samples and register accesses come from logic on clk.
`timescale 1ns/1ps
module avc_top import avc_pkg::*; #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register access port
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  output logic     [7:0]  reg_rdata,
  // Sample input stream
  input wire logic        smp_in_valid,
  output logic            smp_in_ready,
  input wire logic [W-1:0] smp_in_left,
  input wire logic [W-1:0] smp_in_right,
  // Sample output stream
  output logic            smp_out_valid,
  input wire logic        smp_out_ready,
  output logic [W-1:0]    smp_out_left,
  output logic [W-1:0]    smp_out_right,
  // Status
  output logic            adc_left_pwr,
  output logic            adc_right_pwr,
  output logic [6:0]      left_vol_applied,
  output logic [6:0]      right_vol_applied,
  output logic            vol_settling
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_s1_q;
  logic rst_s2_q;

  // Assert at once, release after two edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] pwr_step_q;
  logic [7:0] fine_mute_q;
  logic [6:0] lvol_q;
  logic [6:0] rvol_q;
  logic [7:0] rdata_q;

  // Software writes; reserved bits of the control register are kept as written
  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      pwr_step_q  <= RST_PWR_STEP;
      fine_mute_q <= RST_FINE_MUTE;
      lvol_q      <= RST_VOL;
      rvol_q      <= RST_VOL;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        ADDR_PWR_STEP:  pwr_step_q  <= reg_wdata;
        ADDR_FINE_MUTE: fine_mute_q <= reg_wdata;
        ADDR_LVOL:      lvol_q      <= reg_wdata[VOL_HI:0];
        ADDR_RVOL:      rvol_q      <= reg_wdata[VOL_HI:0];
        default:        ;
      endcase
    end
  end

  // Read data, registered; volume bit 7 has no storage
  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      rdata_q <= RD_UNMAPPED;
    else
    begin
      case (reg_addr)
        ADDR_PWR_STEP:  rdata_q <= pwr_step_q;
        ADDR_FINE_MUTE: rdata_q <= fine_mute_q;
        ADDR_LVOL:      rdata_q <= {1'b0, lvol_q};
        ADDR_RVOL:      rdata_q <= {1'b0, rvol_q};
        default:        rdata_q <= RD_UNMAPPED;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Volume code mapping

  // Code to signed half-dB; reserved positive codes clamp to +20 dB
  function automatic logic signed [6:0] map_vol(input logic [6:0] code);
    logic signed [6:0] r;
    r = $signed(code);
    if (code >= VOL_ZERO_LO && code < VOL_MIN_CODE)
      r = '0;
    else if (code > VOL_MAX_CODE && code < VOL_ZERO_LO)
      r = $signed(VOL_MAX_CODE);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel controls

  avc_step_t         step_mode;
  logic [1:0]        pwr_en;
  logic [1:0]        mute;
  logic [2:0]        fine_sel [2];
  logic signed [6:0] vol_tgt  [2];

  assign step_mode   = avc_step_t'(pwr_step_q[STEP_HI:STEP_LO]);
  assign pwr_en[0]   = pwr_step_q[BIT_LPWR];
  assign pwr_en[1]   = pwr_step_q[BIT_RPWR];
  assign mute[0]     = fine_mute_q[BIT_LMUTE];
  assign mute[1]     = fine_mute_q[BIT_RMUTE];
  assign fine_sel[0] = fine_mute_q[LFINE_HI:LFINE_LO];
  assign fine_sel[1] = fine_mute_q[RFINE_HI:RFINE_LO];
  assign vol_tgt[0]  = map_vol(lvol_q);
  assign vol_tgt[1]  = map_vol(rvol_q);

  // Power flags to the analog side
  logic lpwr_q;
  logic rpwr_q;

  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      lpwr_q <= 1'b0;
      rpwr_q <= 1'b0;
    end
    else
    begin
      lpwr_q <= pwr_en[0];
      rpwr_q <= pwr_en[1];
    end
  end

  assign adc_left_pwr  = lpwr_q;
  assign adc_right_pwr = rpwr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample FIFO

  avc_stream_if #(.W(2 * W)) in_if ();
  avc_stream_if #(.W(2 * W)) out_if ();

  assign in_if.valid  = smp_in_valid;
  assign in_if.data   = {smp_in_left, smp_in_right};
  assign smp_in_ready = in_if.ready;

  avc_fifo #(
    .W     (2 * W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_s2_q),
    .wr    (in_if.sink),
    .rd    (out_if.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output handshake and sample-period ticks

  logic out_valid_q;
  logic pop;
  logic half_q;
  logic step_tick;
  logic step_jump;

  // A popped sample marks one sample period
  assign out_if.ready = ~out_valid_q | smp_out_ready;
  assign pop          = out_if.valid & out_if.ready;

  // Reserved code 11 behaves as stepping disabled
  assign step_jump = (step_mode == STEP_OFF) | (step_mode == STEP_RSVD);
  assign step_tick = pop & ((step_mode == STEP_EVERY) |
                            ((step_mode == STEP_HALF) & half_q));

  // Output valid holds until the consumer takes it
  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      out_valid_q <= 1'b0;
    else if (pop)
      out_valid_q <= 1'b1;
    else if (smp_out_ready)
      out_valid_q <= 1'b0;
  end

  // Alternate sample periods for half-rate stepping
  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      half_q <= 1'b0;
    else if (step_mode != STEP_HALF)
      half_q <= 1'b0;
    else if (pop)
      half_q <= ~half_q;
  end

  assign smp_out_valid = out_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channels: soft-stepped volume and gain

  logic signed [W-1:0] smp_raw [2];
  logic signed [6:0]   vol_app [2];
  logic signed [W-1:0] smp_res [2];
  logic [1:0]          settling;

  assign smp_raw[0] = $signed(out_if.data[2*W-1:W]);
  assign smp_raw[1] = $signed(out_if.data[W-1:0]);

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic signed [6:0]   vol_q;
    logic signed [W-1:0] res_q;
    logic signed [W-1:0] gained;

    // Applied volume walks to target, or jumps when stepping is off
    always_ff @(posedge clk or negedge rst_s2_q)
    begin
      if (!rst_s2_q)
        vol_q <= $signed(RST_VOL);
      else if (step_jump)
        vol_q <= vol_tgt[ch];
      else if (step_tick && vol_q < vol_tgt[ch])
        vol_q <= vol_q + 7'sd1;
      else if (step_tick && vol_q > vol_tgt[ch])
        vol_q <= vol_q - 7'sd1;
    end

    avc_gain #(
      .W       (W)
    ) u_gain (
      .smp_in  (smp_raw[ch]),
      .vol_hdb (vol_q),
      .fine    (fine_sel[ch]),
      .pass    (pwr_en[ch] & ~mute[ch]),
      .smp_out (gained)
    );

    // Result captured with each popped sample
    always_ff @(posedge clk or negedge rst_s2_q)
    begin
      if (!rst_s2_q)
        res_q <= '0;
      else if (pop)
        res_q <= gained;
    end

    assign vol_app[ch]  = vol_q;
    assign smp_res[ch]  = res_q;
    assign settling[ch] = (vol_q != vol_tgt[ch]);
  end

  // Settling flag shows stepping in progress
  logic settling_q;

  always_ff @(posedge clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      settling_q <= 1'b0;
    else
      settling_q <= |settling;
  end

  assign smp_out_left      = smp_res[0];
  assign smp_out_right     = smp_res[1];
  assign left_vol_applied  = vol_app[0];
  assign right_vol_applied = vol_app[1];
  assign vol_settling      = settling_q;

endmodule // avc_top

// ### inc/avc_pkg.sv
// Constants shared by the stereo ADC volume/mute control block.
// Assumes the register map sits in the codec's page-0 byte address space.
package avc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PWR_STEP  = 8'h51;
  localparam logic [7:0] ADDR_FINE_MUTE = 8'h52;
  localparam logic [7:0] ADDR_LVOL      = 8'h53;
  localparam logic [7:0] ADDR_RVOL      = 8'h54;

  // Reset values
  localparam logic [7:0] RST_PWR_STEP  = 8'h00;
  localparam logic [7:0] RST_FINE_MUTE = 8'h88;
  localparam logic [6:0] RST_VOL       = 7'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // Field positions
  localparam int BIT_LPWR  = 7;
  localparam int BIT_RPWR  = 6;
  localparam int STEP_HI   = 1;
  localparam int STEP_LO   = 0;
  localparam int BIT_LMUTE = 7;
  localparam int LFINE_HI  = 6;
  localparam int LFINE_LO  = 4;
  localparam int BIT_RMUTE = 3;
  localparam int RFINE_HI  = 2;
  localparam int RFINE_LO  = 0;
  localparam int VOL_HI    = 6;

  // Soft-step field codes
  typedef enum logic [1:0] {
    STEP_EVERY = 2'h0,
    STEP_HALF  = 2'h1,
    STEP_OFF   = 2'h2,
    STEP_RSVD  = 2'h3
  } avc_step_t;

  // Coarse volume codes, in 0.5 dB units
  localparam logic [6:0] VOL_MAX_CODE  = 7'h28;  // +20 dB
  localparam logic [6:0] VOL_MIN_CODE  = 7'h68;  // -12 dB
  localparam logic [6:0] VOL_ZERO_LO   = 7'h40;  // Printed 0 dB band start
  localparam logic [2:0] FINE_MAX_CODE = 3'h4;   // -0.4 dB

  // Gain arithmetic: 12 half-dB steps per octave, Q2.14 tables
  localparam logic [6:0] HDB_PER_OCT = 7'h0C;
  localparam int         GAIN_FRAC   = 14;
  localparam int         BASE_OCT    = 2;        // -12 dB is two octaves down
  localparam logic [15:0] MANT_TBL [12] = '{
    16'h4000, 16'h43CB, 16'h47CF, 16'h4C10, 16'h5092, 16'h5558,
    16'h5A67, 16'h5FC2, 16'h656F, 16'h6B72, 16'h71CF, 16'h788E};
  localparam logic [15:0] FINE_TBL [5] = '{
    16'h4000, 16'h3F44, 16'h3E8B, 16'h3DD4, 16'h3D1F};

endpackage

// ### inc/avc_stream_if.sv
// Valid/ready stream carrier between the block's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface avc_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ### verilog/avc_fifo.sv
// Sample FIFO with registered valid/ready flags.
// Assumes DEPTH is a power of two; reset is already synchronised.
`timescale 1ns/1ps
module avc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stream sides
  avc_stream_if.sink   wr,
  avc_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          ready_q;
  logic          valid_q;
  logic          push;
  logic          pop;

  // Handshakes; flags are flops so ports come straight from registers
  assign push     = wr.valid & ready_q;
  assign pop      = valid_q & rd.ready;
  assign wr.ready = ready_q;
  assign rd.valid = valid_q;
  assign rd.data  = mem[rd_ptr_q];
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // Storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= wr.data;
  end

  // Pointers and flags
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ready_q  <= 1'b0;
      valid_q  <= 1'b0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      cnt_q    <= cnt_d;
      ready_q  <= (cnt_d != (AW+1)'(DEPTH));
      valid_q  <= (cnt_d != '0);
    end
  end
endmodule // avc_fifo

// ### verilog/avc_gain.sv
// Combinational gain for one channel: coarse half-dB, fine tenth-dB, gate.
// Assumes the volume is already mapped to signed half-dB, -24..+40.
`timescale 1ns/1ps
module avc_gain import avc_pkg::*; #(
  parameter int W = 16
) (
  // Inputs
  input wire logic signed [W-1:0] smp_in,
  input wire logic signed [6:0]   vol_hdb,
  input wire logic        [2:0]   fine,
  input wire logic                pass,
  // Result
  output logic signed [W-1:0]     smp_out
);
  localparam int PW = W + 40;

  logic [6:0]           idx;
  logic [6:0]           oct;
  logic [6:0]           rem;
  logic [2:0]           fine_c;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;
  logic signed [PW-1:0] lim_hi;
  logic signed [PW-1:0] lim_lo;

  // Octave and step within octave; -12 dB maps to index zero
  assign idx    = 7'(vol_hdb) - VOL_MIN_CODE;
  assign oct    = idx / HDB_PER_OCT;
  assign rem    = idx % HDB_PER_OCT;
  assign fine_c = (fine > FINE_MAX_CODE) ? FINE_MAX_CODE : fine;

  // 6 dB taken as one octave; error is under 0.1 dB over the range
  assign prod   = smp_in * $signed(MANT_TBL[rem[3:0]]) * $signed(FINE_TBL[fine_c]);
  assign scaled = (prod <<< oct) >>> (2 * GAIN_FRAC + BASE_OCT);
  assign lim_hi = $signed({{(PW-W+1){1'b0}}, {(W-1){1'b1}}});
  assign lim_lo = $signed({{(PW-W+1){1'b1}}, {(W-1){1'b0}}});

  // Saturate, then gate on power and mute
  always_comb
  begin
    smp_out = '0;
    if (pass)
    begin
      if (scaled > lim_hi)
        smp_out = lim_hi[W-1:0];
      else if (scaled < lim_lo)
        smp_out = lim_lo[W-1:0];
      else
        smp_out = scaled[W-1:0];
    end
  end
endmodule // avc_gain

// ### test/avc_props.sv
// Port checker for the stereo volume, mute and power block.
// Assumes it is bound to avc_top and sees only its ports.
`timescale 1ns/1ps
module avc_props import avc_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // Register port
  input wire logic         reg_wr_en,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic [7:0]   reg_rdata,
  // Output stream
  input wire logic         smp_out_valid,
  input wire logic         smp_out_ready,
  input wire logic [W-1:0] smp_out_left,
  input wire logic [W-1:0] smp_out_right,
  // Status
  input wire logic         adc_left_pwr,
  input wire logic         adc_right_pwr,
  input wire logic [6:0]   left_vol_applied,
  input wire logic         vol_settling
);
  logic [1:0] up_q;
  logic [2:0] quiet_q;
  logic [7:0] pwr_q;
  logic [7:0] fine_q;
  logic       take_q;

  ////////////////////////////////////////////////////////////////////////////
  // Hold off checks until the internal two-flop reset has let go
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  // Cycles since the last register write, saturating
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) quiet_q <= 3'h7;
    else if (reg_wr_en) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  // Mirrors of the control registers
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) pwr_q <= RST_PWR_STEP;
    else if (reg_wr_en && reg_addr == ADDR_PWR_STEP) pwr_q <= reg_wdata;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) fine_q <= RST_FINE_MUTE;
    else if (reg_wr_en && reg_addr == ADDR_FINE_MUTE) fine_q <= reg_wdata;
  // A word seen now is fresh if the output stage was free last cycle
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) take_q <= 1'b0;
    else take_q <= !smp_out_valid || smp_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || up_q != 2'h3);

  a_lpwr_copy: assert property (quiet_q >= 3'h2 |-> adc_left_pwr == pwr_q[BIT_LPWR])
    else $error("left power output differs from control bit");
  a_rpwr_copy: assert property (quiet_q >= 3'h2 |-> adc_right_pwr == pwr_q[BIT_RPWR])
    else $error("right power output differs from control bit");
  a_vol_msb_zero: assert property (reg_addr == ADDR_LVOL || reg_addr == ADDR_RVOL |=> !reg_rdata[7])
    else $error("volume register top bit read back set");
  a_fine_readback: assert property (reg_addr == ADDR_FINE_MUTE |=> reg_rdata == $past(fine_q))
    else $error("fine gain register read back wrong");
  a_lmute_silent: assert property (smp_out_valid && take_q && $past(fine_q[BIT_LMUTE]) |-> smp_out_left == '0)
    else $error("muted left channel not silent");
  a_rmute_silent: assert property (smp_out_valid && take_q && $past(fine_q[BIT_RMUTE]) |-> smp_out_right == '0)
    else $error("muted right channel not silent");
  a_jump_settled: assert property (pwr_q[STEP_HI] && quiet_q >= 3'h3 |-> !vol_settling)
    else $error("volume still settling with stepping off");
  a_step_unit: assert property (!pwr_q[STEP_HI] && !$past(pwr_q[STEP_HI])
    |-> 7'(left_vol_applied - $past(left_vol_applied)) inside {7'h00, 7'h01, 7'h7F})
    else $error("applied volume moved more than one step");
  a_half_rate: assert property (pwr_q[1:0] == STEP_HALF && $past(pwr_q[1:0]) == STEP_HALF
    && $changed(left_vol_applied) |=> $stable(left_vol_applied))
    else $error("applied volume stepped on consecutive cycles");

  // Main scenarios
  c_word_taken: cover property (smp_out_valid && smp_out_ready);
  c_settling: cover property (vol_settling ##1 !vol_settling);
  c_half_step: cover property (pwr_q[1:0] == STEP_HALF && $changed(left_vol_applied));
endmodule // avc_props

bind avc_top avc_props #(.W(W)) u_props (.*);

// ### test/testbench.sv
// Self-checking bench for the stereo volume, mute and power block.
// Assumes avc_top with 16-bit samples, a 16-word FIFO and a 10 MHz clock.
`timescale 1ns/1ps
module testbench import avc_pkg::*;;
  localparam int DEPTH = 16;
  logic        clk, rst_b, reg_wr_en, smp_in_valid, smp_in_ready, smp_out_valid, smp_out_ready;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] in_l, in_r, out_l, out_r;
  logic        pwr_l, pwr_r, settling;
  logic [6:0]  vol_l, vol_r;
  int          failures, samples_checked;
  // Volume codes and the gain each gives to an input of 1000
  logic [7:0]  vcode [6] = '{8'h00, 8'h0C, 8'h18, 8'h74, 8'h68, 8'h50};
  logic [15:0] vexp  [6] = '{16'h03E8, 16'h07D0, 16'h0FA0, 16'h01F4, 16'h00FA, 16'h03E8};

  avc_top DUT (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .smp_in_valid(smp_in_valid), .smp_in_ready(smp_in_ready), .smp_in_left(in_l),
    .smp_in_right(in_r), .smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready), .smp_out_left(out_l),
    .smp_out_right(out_r), .adc_left_pwr(pwr_l), .adc_right_pwr(pwr_r), .left_vol_applied(vol_l),
    .right_vol_applied(vol_r), .vol_settling(settling));

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_smp(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A handshake that never came ends the run at once
  task automatic hang(input string what);
    failures++;
    $display("ERROR %s expected handshake seen none", what);
    tally_and_finish();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register and stream drivers; all change just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    chk_reg(what, exp, reg_rdata);
  endtask
  task automatic xfer(input logic [15:0] l, input logic [15:0] r, input logic [15:0] el, input logic [15:0] er);
    int n;
    @(posedge clk);
    smp_in_valid <= 1'b1;
    in_l         <= l;
    in_r         <= r;
    n = 0;
    do @(posedge clk); while (!smp_in_ready && ++n < 200);
    if (smp_in_ready !== 1'b1) hang("input ready");
    smp_in_valid  <= 1'b0;
    smp_out_ready <= 1'b1;
    n = 0;
    do @(posedge clk); while (!smp_out_valid && ++n < 200);
    if (smp_out_valid !== 1'b1) hang("output valid");
    smp_out_ready <= 1'b0;
    chk_smp("left out", el, out_l);
    chk_smp("right out", er, out_r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(ADDR_PWR_STEP, RST_PWR_STEP, "control reg");
    rd_chk(ADDR_FINE_MUTE, RST_FINE_MUTE, "fine reg");
    rd_chk(ADDR_LVOL, 8'h00, "left volume reg");
    rd_chk(ADDR_RVOL, 8'h00, "right volume reg");
    rd_chk(8'h50, RD_UNMAPPED, "unmapped read");
    chk_reg("power pins", 8'h00, {6'h00, pwr_l, pwr_r});
    xfer(16'h0100, 16'h0100, 16'h0000, 16'h0000);
    $display("test reset finished");
  endtask
  task automatic t_regs;
    wr(ADDR_PWR_STEP, 8'hC2);
    rd_chk(ADDR_PWR_STEP, 8'hC2, "control reg");
    chk_reg("power pins", 8'h03, {6'h00, pwr_l, pwr_r});
    wr(ADDR_LVOL, 8'h7F);
    rd_chk(ADDR_LVOL, 8'h7F, "left volume top bit");
    wr(8'h50, 8'hAA);
    rd_chk(8'h50, RD_UNMAPPED, "unmapped write");
    wr(ADDR_FINE_MUTE, 8'h4A);
    rd_chk(ADDR_FINE_MUTE, 8'h4A, "fine reg");
    $display("test registers finished");
  endtask
  // Stepping off, so each new volume lands before the sample
  task automatic t_gain;
    wr(ADDR_FINE_MUTE, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_LVOL, vcode[i]);
      wr(ADDR_RVOL, vcode[i]);
      xfer(16'h03E8, 16'hFC18, vexp[i], 16'(-vexp[i]));
    end
    wr(ADDR_LVOL, 8'h28);
    wr(ADDR_RVOL, 8'h28);
    xfer(16'h7000, 16'h9000, 16'h7FFF, 16'h8000);
    wr(ADDR_LVOL, 8'h00);
    wr(ADDR_RVOL, 8'h00);
    wr(ADDR_FINE_MUTE, 8'h44);
    xfer(16'h03E8, 16'h03E8, 16'h03BB, 16'h03BB);
    $display("test gain finished");
  endtask
  task automatic t_mute;
    wr(ADDR_FINE_MUTE, 8'h80);
    xfer(16'h03E8, 16'h03E8, 16'h0000, 16'h03E8);
    wr(ADDR_FINE_MUTE, 8'h08);
    xfer(16'h03E8, 16'h03E8, 16'h03E8, 16'h0000);
    wr(ADDR_FINE_MUTE, 8'h00);
    wr(ADDR_PWR_STEP, 8'h42);
    xfer(16'h03E8, 16'h03E8, 16'h0000, 16'h03E8);
    wr(ADDR_PWR_STEP, 8'h82);
    xfer(16'h03E8, 16'h03E8, 16'h03E8, 16'h0000);
    $display("test mute finished");
  endtask
  // Applied volume moves only as samples are popped while stepping is on
  task automatic t_step;
    wr(ADDR_PWR_STEP, 8'hC0);
    wr(ADDR_LVOL, 8'h04);
    wr(ADDR_RVOL, 8'h7C);
    for (int k = 1; k <= 4; k++)
    begin
      xfer(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      chk_reg("applied after pop", 8'(k), {1'b0, vol_l});
      chk_reg("right applied after pop", 8'h80 - 8'(k), {1'b0, vol_r});
    end
    wr(ADDR_PWR_STEP, 8'hC1);
    wr(ADDR_LVOL, 8'h00);
    for (int k = 1; k <= 4; k++)
    begin
      xfer(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      if (k % 2 == 0) chk_reg("applied half rate", 8'(4 - k / 2), {1'b0, vol_l});
    end
    chk_reg("settling flag", 8'h01, {7'h00, settling});
    wr(ADDR_PWR_STEP, 8'hC2);
    rd_chk(ADDR_PWR_STEP, 8'hC2, "control reg");
    chk_reg("applied after jump", 8'h00, {1'b0, vol_l});
    $display("test stepping finished");
  endtask
  // Stall the far side until the buffer refuses, then drain in order
  task automatic t_fifo;
    int taken;
    taken = 0;
    @(posedge clk);
    smp_in_valid <= 1'b1;
    in_l         <= 16'h0000;
    in_r         <= 16'h0000;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (smp_in_ready)
      begin
        taken++;
        in_l <= 16'(taken);
        in_r <= 16'(taken);
      end
    end
    smp_in_valid <= 1'b0;
    chk_reg("words accepted", 8'(DEPTH + 1), 8'(taken));
    for (int j = 0; j <= DEPTH; j++)
    begin
      smp_out_ready <= 1'b1;
      @(posedge clk);
      chk_smp("drained word", 16'(j), smp_out_valid ? out_l : 16'hDEAD);
    end
    smp_out_ready <= 1'b0;
    repeat (2) @(posedge clk);
    chk_reg("empty after drain", 8'h00, {7'h00, smp_out_valid});
    $display("test buffer finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_b           = 1'b0;
    reg_wr_en       = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    smp_in_valid    = 1'b0;
    smp_out_ready   = 1'b0;
    in_l            = 16'h0000;
    in_r            = 16'h0000;
    failures        = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_gain();
    t_mute();
    t_step();
    t_fifo();
    tally_and_finish();
  end
endmodule // testbench
